/* File: hw/msb_defines.vh */
// Contract
// - nibble exchange swaps the two halves of the addressed byte and writes it back there.
// - compare skip subtracts the operand from the accumulator, updates zero and carry, keeps no difference, and skips when equal.
// - decrement skip lowers the addressed byte by one, stores it, and skips when the result is zero.
// - bank zero bit set always writes bank 0, forcing the chosen bit of the addressed byte to one.
`ifndef MSB_DEFINES_VH
`define MSB_DEFINES_VH
// ********************************
// opcodes on op_code
// ********************************
`define MSB_OP_NOP      3'h0
`define MSB_OP_NIB_XCHG 3'h1
`define MSB_OP_CMP_IMM  3'h2
`define MSB_OP_CMP_MEM  3'h3
`define MSB_OP_DEC_SKIP 3'h4
`define MSB_OP_BANK0_SET 3'h5
// ********************************
// widths and fixed values
// ********************************
`define MSB_BANK_ZERO   1'h0
`define MSB_LO_NIB      3:0
`define MSB_HI_NIB      7:4
`define MSB_ONE         8'h01
`define MSB_ZERO        8'h00
`define MSB_BORROW_BIT  8
`define MSB_BYTE        7:0
`endif

/* File: hw/msb_alu.v */
`timescale 1ns/1ps
`include "msb_defines.vh"
// ********************************
// combinational result unit
// ********************************
module msb_alu (
  input  wire [2:0] op,
  input  wire [7:0] acc,
  input  wire [7:0] mem,
  input  wire [7:0] imm,
  input  wire [2:0] bit_sel,
  output reg  [7:0] wdata,
  output reg        wr,
  output reg        flag_wr,
  output reg        zero,
  output reg        carry,
  output reg        skip
);
  reg [8:0] diff;
  reg [7:0] opnd;
  reg [7:0] dec;
  always @*
  begin
    wdata   = `MSB_ZERO;
    wr      = 1'b0;
    flag_wr = 1'b0;
    zero    = 1'b0;
    carry   = 1'b0;
    skip    = 1'b0;
    opnd    = (op == `MSB_OP_CMP_IMM) ? imm : mem;
    diff    = {1'b0, acc} - {1'b0, opnd};
    dec     = mem - `MSB_ONE;
    case (op)
      `MSB_OP_NIB_XCHG:
      begin
        wdata = {mem[`MSB_LO_NIB], mem[`MSB_HI_NIB]};
        wr    = 1'b1;
      end
      `MSB_OP_CMP_IMM, `MSB_OP_CMP_MEM:
      begin
        // carry set means no borrow
        flag_wr = 1'b1;
        zero    = (diff[`MSB_BYTE] == `MSB_ZERO);
        carry   = ~diff[`MSB_BORROW_BIT];
        skip    = (acc == opnd);
      end
      `MSB_OP_DEC_SKIP:
      begin
        wdata = dec;
        wr    = 1'b1;
        skip  = (dec == `MSB_ZERO);
      end
      `MSB_OP_BANK0_SET:
      begin
        wdata = mem | (`MSB_ONE << bit_sel);
        wr    = 1'b1;
      end
      default:
      begin
        wr = 1'b0;
      end
    endcase
  end
endmodule

/* File: hw/msb_exec.v */
`timescale 1ns/1ps
`include "msb_defines.vh"
// ********************************
// execute stage for skip and bit ops
// ********************************
module msb_exec (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       clk_en,
  input  wire       op_valid,
  input  wire [2:0] op_code,
  input  wire [7:0] op_addr,
  input  wire [7:0] op_imm,
  input  wire [2:0] op_bit,
  input  wire       bank_sel,
  input  wire [7:0] acc,
  input  wire [7:0] mem_rdata,
  output reg        mem_we,
  output reg  [7:0] mem_waddr,
  output reg        mem_wbank,
  output reg  [7:0] mem_wdata,
  output reg        flag_we,
  output reg        zero_flag,
  output reg        carry_flag,
  output reg        skip_active,
  output reg        op_done
);
  // mem_rdata is the byte at op_addr; for a bank zero bit set the core must read bank 0
  localparam ST_RUN  = 2'b01;
  localparam ST_SKIP = 2'b10;
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg        mem_we_d;
  reg  [7:0] mem_waddr_d;
  reg        mem_wbank_d;
  reg  [7:0] mem_wdata_d;
  reg        flag_we_d;
  reg        zero_flag_d;
  reg        carry_flag_d;
  reg        skip_active_d;
  reg        op_done_d;
  reg        is_known;
  reg        is_bank0;
  reg        is_cmp;
  reg        is_dec;
  wire       slot_live;
  wire       slot_squash;
  wire [7:0] alu_wdata;
  wire       alu_wr;
  wire       alu_fwr;
  wire       alu_z;
  wire       alu_c;
  wire       alu_skip;

  msb_alu u_alu (
    .op      (op_code),
    .acc     (acc),
    .mem     (mem_rdata),
    .imm     (op_imm),
    .bit_sel (op_bit),
    .wdata   (alu_wdata),
    .wr      (alu_wr),
    .flag_wr (alu_fwr),
    .zero    (alu_z),
    .carry   (alu_c),
    .skip    (alu_skip)
  );

  // ********************************
  // opcode class decode
  // ********************************
  always @*
  begin
    is_known = 1'b0;
    is_bank0 = 1'b0;
    is_cmp   = 1'b0;
    is_dec   = 1'b0;
    case (op_code)
      `MSB_OP_NIB_XCHG:
      begin
        is_known = 1'b1;
      end
      `MSB_OP_CMP_IMM, `MSB_OP_CMP_MEM:
      begin
        is_known = 1'b1;
        is_cmp   = 1'b1;
      end
      `MSB_OP_DEC_SKIP:
      begin
        is_known = 1'b1;
        is_dec   = 1'b1;
      end
      `MSB_OP_BANK0_SET:
      begin
        is_known = 1'b1;
        is_bank0 = 1'b1;
      end
      default:
      begin
        // nop and spare codes write nothing
        is_known = 1'b0;
      end
    endcase
  end

  // a slot either runs or is eaten by a pending skip
  assign slot_live   = op_valid && (state_q == ST_RUN);
  assign slot_squash = op_valid && (state_q == ST_SKIP);

  // ********************************
  // skip sequencer
  // ********************************
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
      begin
        // only a compare or a decrement may arm a skip
        if (slot_live && (is_cmp || is_dec) && alu_skip)
          state_d = ST_SKIP;
      end
      ST_SKIP:
      begin
        if (op_valid)
          state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ********************************
  // write port next values
  // ********************************
  always @*
  begin
    // the strobe drops by default; address, bank and data hold for the memory
    mem_we_d    = 1'b0;
    mem_waddr_d = mem_waddr;
    mem_wbank_d = mem_wbank;
    mem_wdata_d = mem_wdata;
    if (slot_live)
    begin
      mem_we_d    = is_known && alu_wr;
      mem_waddr_d = op_addr;
      mem_wdata_d = alu_wdata;
      mem_wbank_d = is_bank0 ? `MSB_BANK_ZERO : bank_sel;
    end
    else if (slot_squash)
    begin
      // an eaten slot is consumed but never reaches memory
      mem_we_d = 1'b0;
    end
  end

  // ********************************
  // flag next values
  // ********************************
  always @*
  begin
    flag_we_d    = 1'b0;
    zero_flag_d  = zero_flag;
    carry_flag_d = carry_flag;
    if (slot_live && alu_fwr)
    begin
      flag_we_d    = 1'b1;
      zero_flag_d  = alu_z;
      carry_flag_d = alu_c;
    end
  end

  // ********************************
  // sequencer status next values
  // ********************************
  always @*
  begin
    // skip_active looks ahead so the core can discard its prefetch in time
    skip_active_d = (state_d == ST_SKIP);
    op_done_d     = op_valid;
  end

  // ********************************
  // registered outputs
  // ********************************
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q     <= ST_RUN;
      mem_we      <= 1'b0;
      mem_waddr   <= `MSB_ZERO;
      mem_wbank   <= `MSB_BANK_ZERO;
      mem_wdata   <= `MSB_ZERO;
      flag_we     <= 1'b0;
      zero_flag   <= 1'b0;
      carry_flag  <= 1'b0;
      skip_active <= 1'b0;
      op_done     <= 1'b0;
    end
    else if (clk_en)
    begin
      // clk_en low freezes every flop, the skip state included
      state_q     <= state_d;
      mem_we      <= mem_we_d;
      mem_waddr   <= mem_waddr_d;
      mem_wbank   <= mem_wbank_d;
      mem_wdata   <= mem_wdata_d;
      flag_we     <= flag_we_d;
      zero_flag   <= zero_flag_d;
      carry_flag  <= carry_flag_d;
      skip_active <= skip_active_d;
      op_done     <= op_done_d;
    end
  end
endmodule

/* File: dv/msb_exec_assertions.sv */
`timescale 1ns/1ps
// ****
// rule checker
// ****
module msb_exec_chk (
  input wire       core_clk,
  input wire       rst,
  input wire       clk_en,
  input wire       op_valid,
  input wire [2:0] op_code,
  input wire [7:0] op_addr,
  input wire [7:0] op_imm,
  input wire [2:0] op_bit,
  input wire [7:0] acc,
  input wire [7:0] mem_rdata,
  input wire       mem_we,
  input wire [7:0] mem_waddr,
  input wire       mem_wbank,
  input wire [7:0] mem_wdata,
  input wire       flag_we,
  input wire       zero_flag,
  input wire       carry_flag,
  input wire       skip_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // taken and not squashed
  wire go = clk_en && op_valid && !skip_active;
  swap_write_a:
    assert property (go && op_code == 3'h1 |=> mem_we && mem_waddr == $past(op_addr)
      && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}) else $error("swap bad");
  cmp_flags_a:
    assert property (go && op_code == 3'h3 |=> flag_we && !mem_we && skip_active == zero_flag
      && zero_flag == ($past(acc) == $past(mem_rdata))
      && carry_flag == ($past(acc) >= $past(mem_rdata))) else $error("compare bad");
  cmp_imm_a:
    assert property (go && op_code == 3'h2 |=> flag_we && !mem_we && skip_active == zero_flag
      && zero_flag == ($past(acc) == $past(op_imm))
      && carry_flag == ($past(acc) >= $past(op_imm))) else $error("compare immediate bad");
  dec_skip_a:
    assert property (go && op_code == 3'h4 |=> mem_we && mem_wdata == $past(mem_rdata) - 8'h01
      && skip_active == (mem_wdata == 8'h00)) else $error("decrement bad");
  bank0_set_a:
    assert property (go && op_code == 3'h5 |=> mem_we && !mem_wbank
      && mem_wdata == ($past(mem_rdata) | (8'h01 << $past(op_bit)))) else $error("bit set bad");
  skip_squash_a:
    assert property (clk_en && op_valid && skip_active |=> !mem_we && !flag_we && !skip_active)
      else $error("squash bad");
  cover property (go && op_code == 3'h4 ##1 skip_active);
  cover property (clk_en && op_valid && skip_active);
  cover property (go && op_code == 3'h5 && op_bit == 3'h7);
  cover property (go && op_code == 3'h3 ##1 skip_active);
endmodule
bind msb_exec msb_exec_chk u_chk (.*);

/* File: dv/testbench.sv */
`timescale 1ns/1ps
// ****
// bench
// ****
module testbench;
  reg        core_clk = 1'b0;
  reg        rst = 1'b1;
  reg        op_valid = 1'b0;
  reg  [2:0] op_code = 3'h0;
  reg  [7:0] mem_rdata = 8'h00;
  reg  [7:0] acc = 8'h00;
  reg  [2:0] op_bit = 3'h0;
  reg        clk_en = 1'b1;
  wire [7:0] mem_waddr;
  wire       mem_wbank;
  wire       flag_we;
  wire       carry_flag;
  wire       op_done;
  wire       mem_we;
  wire       skip_active;
  wire       zero_flag;
  wire [7:0] mem_wdata;
  int        bad_count = 0;
  int        total_checks = 0;
  int        cyc = 0;
  // op rdata acc bit | we wdata skip
  reg [31:0] rows [0:7] = '{32'h27800386, 32'h80200201, 32'h27800000, 32'h900002FE,
                           32'hA0001F00, 32'h6B4B4001, 32'hA0001C00, 32'h4201E000};
  msb_exec DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .op_addr(mem_rdata), .op_imm(mem_rdata), .op_bit(op_bit),
    .bank_sel(1'b1), .acc(acc), .mem_rdata(mem_rdata), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wbank(mem_wbank), .mem_wdata(mem_wdata),
    .flag_we(flag_we), .zero_flag(zero_flag), .carry_flag(carry_flag),
    .skip_active(skip_active), .op_done(op_done));
  always #20 core_clk = ~core_clk;
  task chk(input string n, input [7:0] s, input [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task put(input [31:0] r);
    op_valid = 1'b1;
    op_code = r[31:29];
    mem_rdata = r[28:21];
    acc = r[20:13];
    op_bit = r[12:10];
  endtask
  task see(input [31:0] r);
    chk("we", {7'h00, mem_we}, {7'h00, r[9]});
    if (r[9]) chk("wdata", mem_wdata, r[8:1]);
    chk("skip", {7'h00, skip_active}, {7'h00, r[0]});
    if (r[31:30] == 2'b01) chk("zero", {7'h00, zero_flag}, {7'h00, r[0]});
    if (r[31:30] == 2'b01) chk("carry", {7'h00, carry_flag}, {7'h00, r[20:13] >= r[28:21]});
    chk("flag_we", {7'h00, flag_we}, {7'h00, r[31:30] == 2'b01});
    chk("done", {7'h00, op_done}, 8'h01);
    if (r[9]) chk("waddr", mem_waddr, r[28:21]);
    if (r[9]) chk("wbank", {7'h00, mem_wbank}, {7'h00, r[31:29] != 3'h5});
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 100)
    begin
      bad_count++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    chk("rst_we", {7'h00, mem_we}, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      put(rows[i]);
      @(posedge core_clk);
      #1 see(rows[i]);
    end
    // pending skip must survive idle cycles
    put(rows[1]);
    @(posedge core_clk);
    #1 op_valid = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk("held", {7'h00, skip_active}, 8'h01);
    chk("idle_done", {7'h00, op_done}, 8'h00);
    put(rows[0]);
    @(posedge core_clk);
    #1 see(rows[2]);
    // clock enable low freezes a decrement that would arm a skip
    clk_en = 1'b0;
    put(rows[1]);
    @(posedge core_clk);
    #1 chk("frozen_skip", {7'h00, skip_active}, 8'h00);
    chk("frozen_we", {7'h00, mem_we}, 8'h00);
    clk_en = 1'b1;
    @(posedge core_clk);
    #1 chk("thawed_skip", {7'h00, skip_active}, 8'h01);
    chk("thawed_we", {7'h00, mem_we}, 8'h01);
    // reset in mid-run drops the pending skip
    op_valid = 1'b0;
    rst = 1'b1;
    @(posedge core_clk);
    #1 rst = 1'b0;
    chk("rst_skip", {7'h00, skip_active}, 8'h00);
    chk("rst_we2", {7'h00, mem_we}, 8'h00);
    put(rows[0]);
    @(posedge core_clk);
    #1 see(rows[0]);
    end_of_test;
  end
endmodule
